// ---- rsdm_map.vh ----
// Constants of the serial data map: channel, class and item codes, ranges and signal count
`ifndef RSDM_MAP_VH
`define RSDM_MAP_VH
// ----------------------------------------
// Channel and item classes
// ----------------------------------------
`define RSDM_CHANNEL      4'h0
`define RSDM_CLS_INPUT    2'h0
`define RSDM_CLS_OUTPUT   2'h1
`define RSDM_CLS_SETTING  2'h2
`define RSDM_CLS_MEMORY   2'h3
// ----------------------------------------
// Input item numbers
// ----------------------------------------
`define RSDM_IN_PHASE1    6'h01
`define RSDM_IN_PHASE2    6'h02
`define RSDM_IN_PHASE3    6'h03
`define RSDM_IN_NEUTRAL   6'h04
`define RSDM_IN_BLOCK     6'h05
// ----------------------------------------
// Output item numbers
// ----------------------------------------
`define RSDM_OUT_FIRST    6'h01
`define RSDM_OUT_LAST_FLAG 6'h08
`define RSDM_OUT_SIG_FIRST 6'h09
`define RSDM_OUT_SIG_LAST 6'h0d
`define RSDM_OUT_RELAY    6'h29
// ----------------------------------------
// Ranges, in hundredths of rated current, and output signal count
// ----------------------------------------
`define RSDM_PHASE_MAX    16'h189c
`define RSDM_NEUTRAL_MAX  16'h0834
`define RSDM_SIG_COUNT    5
`endif

// ---- rsdm_write_guard.v ----
// Password gate for protected write items
`timescale 1ns/1ps
module rsdm_write_guard #(
	parameter PW_W = 16
) (
	input  wire            mclk_in,
	input  wire            sys_rst_in,
	input  wire            pw_strobe_in,
	input  wire [PW_W-1:0] pw_value_in,
	input  wire [PW_W-1:0] pw_expect_in,
	input  wire            pw_lock_in,
	output wire            wr_enable_out
);
	reg en_reg;
	reg en_next;

	always @* begin
		en_next = en_reg;
		if (pw_lock_in)
			en_next = 1'b0;
		else if (pw_strobe_in)
			en_next = (pw_value_in == pw_expect_in);
	end

	always @(posedge mclk_in) begin
		if (sys_rst_in)
			en_reg <= 1'b0;
		else
			en_reg <= en_next;
	end

	assign wr_enable_out = en_reg;
endmodule

// ---- rsdm_data_map.v ----
// Serial data map of the overcurrent and earth-fault protection module
// Function
// - All items are served in channel zero only.
// - Polled reads of inputs, settings and memory values answer one cycle after the request.
// - Reads return present values and change no internal state.
// - Protected items accept writes only after the password enabled writing.
// - Phase currents read 0..63 x rated, neutral 0..21 x rated, read-only.
// - Blocking item reads 1 when external blocking is active, else 0.
// - Phase stage start flags read 1 while started.
// - Phase stage trip flags read 1 when tripped.
// - Earth stage start and trip flags read 1 when active.
// - Five output signals readable, writable under password.
// - Relay operate item reads operated state; writing 1 operates relays.
`timescale 1ns/1ps
`include "rsdm_map.vh"
module rsdm_data_map #(
	parameter DATA_W = 16,
	parameter PW_W   = 16
) (
	input  wire              mclk_in,
	input  wire              sys_rst_in,
	// Request from the serial link
	input  wire              req_valid_in,
	input  wire              req_write_in,
	input  wire [3:0]        req_channel_in,
	input  wire [1:0]        req_class_in,
	input  wire [5:0]        req_item_in,
	input  wire [DATA_W-1:0] req_wdata_in,
	// Password handling
	input  wire              pw_strobe_in,
	input  wire [PW_W-1:0]   pw_value_in,
	input  wire [PW_W-1:0]   pw_expect_in,
	input  wire              pw_lock_in,
	// Measurements and protection state
	input  wire [DATA_W-1:0] phase1_current_in,
	input  wire [DATA_W-1:0] phase2_current_in,
	input  wire [DATA_W-1:0] phase3_current_in,
	input  wire [DATA_W-1:0] neutral_current_in,
	input  wire              blocking_input_in,
	input  wire [7:0]        stage_flags_in,
	input  wire [4:0]        signal_drive_in,
	// Setting and memory values served from elsewhere
	input  wire [DATA_W-1:0] ext_rdata_in,
	output wire              ext_rd_out,
	output wire [1:0]        ext_class_out,
	output wire [5:0]        ext_item_out,
	// Answer
	output reg               rsp_valid_out,
	output reg               rsp_error_out,
	output reg  [DATA_W-1:0] rsp_rdata_out,
	// Driven outputs
	output wire [4:0]        output_signals_out,
	output wire              relay_operate_out,
	output wire              write_enabled_out
);
	// ----------------------------------------
	// Password gate
	// ----------------------------------------
	wire wr_en;
	rsdm_write_guard #(.PW_W(PW_W)) u_guard (
		.mclk_in      (mclk_in),
		.sys_rst_in   (sys_rst_in),
		.pw_strobe_in (pw_strobe_in),
		.pw_value_in  (pw_value_in),
		.pw_expect_in (pw_expect_in),
		.pw_lock_in   (pw_lock_in),
		.wr_enable_out(wr_en)
	);
	assign write_enabled_out = wr_en;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire ch_ok  = (req_channel_in == `RSDM_CHANNEL);
	wire is_in  = (req_class_in == `RSDM_CLS_INPUT);
	wire is_out = (req_class_in == `RSDM_CLS_OUTPUT);
	wire is_ext = (req_class_in == `RSDM_CLS_SETTING) || (req_class_in == `RSDM_CLS_MEMORY);
	wire is_sig = is_out && (req_item_in >= `RSDM_OUT_SIG_FIRST)
		&& (req_item_in <= `RSDM_OUT_SIG_LAST);
	wire is_rly = is_out && (req_item_in == `RSDM_OUT_RELAY);
	wire [5:0] sig_idx = req_item_in - `RSDM_OUT_SIG_FIRST;

	// Settings and memory go out combinationally; their data must be valid same cycle
	assign ext_rd_out    = req_valid_in && !req_write_in && ch_ok && is_ext;
	assign ext_class_out = req_class_in;
	assign ext_item_out  = req_item_in;

	// ----------------------------------------
	// Software forcing of output signals
	// ----------------------------------------
	reg [4:0] force_reg;
	reg       relay_reg;
	wire      wr_ok = req_valid_in && req_write_in && ch_ok && wr_en;

	genvar g;
	generate
		for (g = 0; g < `RSDM_SIG_COUNT; g = g + 1) begin : g_sig
			always @(posedge mclk_in) begin
				if (sys_rst_in)
					force_reg[g] <= 1'b0;
				else if (wr_ok && is_sig && sig_idx == g)
					force_reg[g] <= req_wdata_in[0];
			end
		end
	endgenerate

	always @(posedge mclk_in) begin
		if (sys_rst_in)
			relay_reg <= 1'b0;
		else if (wr_ok && is_rly)
			relay_reg <= req_wdata_in[0];
	end

	// Forced bits add to protection drive; software can assert but not mask a trip
	assign output_signals_out = signal_drive_in | force_reg;
	assign relay_operate_out  = relay_reg;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	function [DATA_W-1:0] clip;
		input [DATA_W-1:0] v;
		input [DATA_W-1:0] lim;
		begin
			clip = (v > lim) ? lim : v;
		end
	endfunction

	reg [DATA_W-1:0] rd_next;
	reg              err_next;
	always @* begin
		rd_next  = {DATA_W{1'b0}};
		err_next = 1'b0;
		if (!ch_ok) begin
			err_next = 1'b1;
		end else if (req_write_in) begin
			err_next = !(wr_en && (is_sig || is_rly));
		end else if (is_in) begin
			case (req_item_in)
				`RSDM_IN_PHASE1:  rd_next = clip(phase1_current_in, `RSDM_PHASE_MAX);
				`RSDM_IN_PHASE2:  rd_next = clip(phase2_current_in, `RSDM_PHASE_MAX);
				`RSDM_IN_PHASE3:  rd_next = clip(phase3_current_in, `RSDM_PHASE_MAX);
				`RSDM_IN_NEUTRAL: rd_next = clip(neutral_current_in, `RSDM_NEUTRAL_MAX);
				`RSDM_IN_BLOCK:   rd_next[0] = blocking_input_in;
				default:          err_next = 1'b1;
			endcase
		end else if (is_out) begin
			if (req_item_in >= `RSDM_OUT_FIRST && req_item_in <= `RSDM_OUT_LAST_FLAG)
				rd_next[0] = stage_flags_in[req_item_in[2:0] - 3'h1];
			else if (is_sig)
				rd_next[0] = output_signals_out[sig_idx[2:0]];
			else if (is_rly)
				rd_next[0] = relay_reg;
			else
				err_next = 1'b1;
		end else begin
			rd_next = ext_rdata_in;
		end
	end

	// Reads only capture into the answer register, nothing else changes
	always @(posedge mclk_in) begin
		if (sys_rst_in) begin
			rsp_valid_out <= 1'b0;
			rsp_error_out <= 1'b0;
			rsp_rdata_out <= {DATA_W{1'b0}};
		end else begin
			rsp_valid_out <= req_valid_in;
			if (req_valid_in) begin
				rsp_error_out <= err_next;
				rsp_rdata_out <= rd_next;
			end
		end
	end
endmodule

// ---- rsdm_remote_mdl.sv ----
// Model of the setting and memory value source behind the map
`timescale 1ns/1ps
module rsdm_remote_mdl (
	input  wire        mclk_in,
	input  wire        ext_rd_out,
	input  wire [1:0]  ext_class_out,
	input  wire [5:0]  ext_item_out,
	output wire [15:0] ext_rdata_in
);
	logic t_reg = 1'b0;
	always @(posedge mclk_in) begin
		t_reg <= ~t_reg;
	end
	// Unselected source toggles each cycle so a stale word cannot match
	assign ext_rdata_in = ext_rd_out ? {8'h5a, ext_class_out, ext_item_out} : {16{t_reg}};
endmodule

// ---- rsdm_data_map_chk.sv ----
// Port checker of the serial data map
`timescale 1ns/1ps
module rsdm_data_map_chk (
	input wire        mclk_in,
	input wire        sys_rst_in,
	input wire        req_valid_in,
	input wire        req_write_in,
	input wire [3:0]  req_channel_in,
	input wire [1:0]  req_class_in,
	input wire [5:0]  req_item_in,
	input wire [15:0] req_wdata_in,
	input wire        pw_lock_in,
	input wire [7:0]  stage_flags_in,
	input wire        rsp_valid_out,
	input wire        rsp_error_out,
	input wire [15:0] rsp_rdata_out,
	input wire        relay_operate_out,
	input wire        write_enabled_out
);
	logic fl_reg;
	wire  rd = req_valid_in && !req_write_in && req_channel_in == 4'h0;
	wire  wr = req_valid_in && req_write_in && req_channel_in == 4'h0;
	wire  rly = wr && req_class_in == 2'h1 && req_item_in == 6'h29;
	always @(posedge mclk_in) begin
		fl_reg <= stage_flags_in[req_item_in[2:0] - 3'h1];
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	a_rsp_follows: assert property (req_valid_in |=> rsp_valid_out)
		else $error("no answer one cycle after request");
	a_rsp_unasked: assert property (!req_valid_in |=> !rsp_valid_out)
		else $error("answer without request");
	a_other_channel: assert property (req_valid_in && req_channel_in != 4'h0 |=> rsp_error_out)
		else $error("request outside channel zero accepted");
	a_flag_value: assert property (rd && req_class_in == 2'h1 && req_item_in inside {[6'h01:6'h08]}
		|=> rsp_rdata_out[0] == fl_reg)
		else $error("stage flag read wrong");
	a_input_ro: assert property (wr && req_class_in == 2'h0 |=> rsp_error_out)
		else $error("write to input item accepted");
	a_locked_write: assert property (rly && !write_enabled_out
		|=> rsp_error_out && $stable(relay_operate_out))
		else $error("locked write changed relay");
	a_relay_operate: assert property (rly && req_wdata_in[0] && write_enabled_out
		|=> relay_operate_out && !rsp_error_out)
		else $error("relay not operated");
	a_lock_disables: assert property (pw_lock_in |=> !write_enabled_out)
		else $error("writing enabled after lock");
endmodule

// ---- rsdm_data_map_tb.sv ----
// Testbench of the serial data map
`timescale 1ns/1ps
module rsdm_data_map_tb;
	logic        mclk_in = 1'b0, sys_rst_in = 1'b1, req_valid_in = 1'b0, req_write_in = 1'b0;
	logic        pw_strobe_in = 1'b0, pw_lock_in = 1'b0, blocking_input_in = 1'b0;
	logic        ext_rd_out, rsp_valid_out, rsp_error_out, relay_operate_out, write_enabled_out;
	logic [1:0]  req_class_in = 2'h0, ext_class_out;
	logic [3:0]  req_channel_in = 4'h0;
	logic [4:0]  signal_drive_in = 5'h04, output_signals_out;
	logic [5:0]  req_item_in = 6'h00, ext_item_out, k;
	logic [7:0]  stage_flags_in = 8'h00;
	logic [15:0] req_wdata_in = 16'h0, pw_value_in = 16'h0, pw_expect_in = 16'h3c5a;
	logic [15:0] phase1_current_in = 16'h2000, phase2_current_in = 16'h0123;
	logic [15:0] phase3_current_in = 16'h189c, neutral_current_in = 16'h0900;
	logic [15:0] ext_rdata_in, rsp_rdata_out;
	int          n_fail = 0, checked = 0;
	rsdm_data_map dut_u (.*);
	rsdm_remote_mdl mdl_u (.*);
	initial begin
		forever #50 mclk_in = ~mclk_in;
	end
	task close_out;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", n, e, g);
			n_fail++;
		end
	endtask
	// One request, error flag judged in the answer cycle
	task rq(input logic w, input logic [1:0] c, input logic [5:0] it, input logic e);
		@(posedge mclk_in);
		req_valid_in <= 1'b1;
		req_write_in <= w;
		req_class_in <= c;
		req_item_in <= it;
		req_wdata_in <= 16'h0001;
		@(posedge mclk_in);
		req_valid_in <= 1'b0;
		#1;
		chk("error", {15'h0, e}, {15'h0, rsp_error_out});
	endtask
	task pw(input logic [15:0] v);
		@(posedge mclk_in);
		pw_value_in <= v;
		pw_strobe_in <= 1'b1;
		@(posedge mclk_in);
		pw_strobe_in <= 1'b0;
	endtask
	initial begin
		repeat (6) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		rq(1'b0, 2'h0, 6'h01, 1'b0);
		chk("phase1", 16'h189c, rsp_rdata_out);
		rq(1'b0, 2'h0, 6'h03, 1'b0);
		chk("phase3", 16'h189c, rsp_rdata_out);
		rq(1'b0, 2'h0, 6'h04, 1'b0);
		chk("neutral", 16'h0834, rsp_rdata_out);
		rq(1'b0, 2'h0, 6'h02, 1'b0);
		chk("phase2", 16'h0123, rsp_rdata_out);
		rq(1'b1, 2'h0, 6'h01, 1'b1);
		@(posedge mclk_in) blocking_input_in <= 1'b1;
		rq(1'b0, 2'h0, 6'h05, 1'b0);
		chk("block", 16'h0001, rsp_rdata_out);
		for (k = 6'h01; k <= 6'h08; k++) begin
			@(posedge mclk_in) stage_flags_in <= 8'h01 << (k - 6'h01);
			rq(1'b0, 2'h1, k, 1'b0);
			chk("flag set", 16'h0001, rsp_rdata_out);
			@(posedge mclk_in) stage_flags_in <= ~(8'h01 << (k - 6'h01));
			rq(1'b0, 2'h1, k, 1'b0);
			chk("flag clear", 16'h0000, rsp_rdata_out);
		end
		rq(1'b0, 2'h3, 6'h07, 1'b0);
		chk("memory", 16'h5ac7, rsp_rdata_out);
		@(posedge mclk_in) req_channel_in <= 4'h1;
		rq(1'b0, 2'h0, 6'h01, 1'b1);
		@(posedge mclk_in) req_channel_in <= 4'h0;
		rq(1'b1, 2'h1, 6'h09, 1'b1);
		chk("locked out", 16'h0004, {11'h0, output_signals_out});
		pw(16'h3c5b);
		rq(1'b1, 2'h1, 6'h29, 1'b1);
		chk("locked relay", 16'h0000, {15'h0, relay_operate_out});
		pw(16'h3c5a);
		rq(1'b1, 2'h1, 6'h29, 1'b0);
		rq(1'b0, 2'h1, 6'h29, 1'b0);
		chk("relay", 16'h0001, rsp_rdata_out);
		chk("write enabled", 16'h0001, {15'h0, write_enabled_out});
		for (k = 6'h09; k <= 6'h0d; k++) rq(1'b1, 2'h1, k, 1'b0);
		chk("outputs", 16'h001f, {11'h0, output_signals_out});
		rq(1'b0, 2'h1, 6'h0b, 1'b0);
		chk("signal read", 16'h0001, rsp_rdata_out);
		rq(1'b0, 2'h2, 6'h03, 1'b0);
		chk("setting", 16'h5a83, rsp_rdata_out);
		@(posedge mclk_in) pw_lock_in <= 1'b1;
		@(posedge mclk_in) pw_lock_in <= 1'b0;
		rq(1'b1, 2'h1, 6'h0d, 1'b1);
		chk("write locked", 16'h0000, {15'h0, write_enabled_out});
		close_out;
	end
endmodule
bind rsdm_data_map rsdm_data_map_chk chk_u (.*);
